// >>> logic/gdt_pkg.sv
// Shared constants, register map and helper functions for the gated delay timer bank
package gdt_pkg;

  localparam int CLK_HZ         = 50_000_000;
  localparam int REF_HZ         = 250_000;
  localparam int REF_DIV_CYCLES = CLK_HZ / REF_HZ;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET      = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET    = 8'h04;
  localparam logic [ADDR_W-1:0] TIMER_CFG_OFFSET = 8'h10;

  localparam int CTRL_REF_SEL_BIT = 0;
  localparam int CTRL_MODE_BIT    = 1;
  localparam int CTRL_SDIV_LSB    = 2;
  localparam int SDIV_SEL_W       = 3;
  localparam int TCFG_CNT_LSB     = 0;
  localparam int CNT_SEL_W        = 3;
  localparam int TCFG_PDIV_LSB    = 4;
  localparam int PDIV_SEL_W       = 4;
  localparam int TCFG_COUNT_LSB   = 16;
  localparam int STATUS_GATE_LSB  = 16;

  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] TIMER_CFG_RESET = 32'h0000_0000;

  localparam int CNT_W      = 9;
  localparam int SDIV_CNT_W = 9;
  localparam int PDIV_CNT_W = 15;
  localparam int MAX_TIMERS = 16;

  localparam logic [CNT_W-1:0]      SHARED_CNT_MIN = 9'h002;
  localparam logic [CNT_W-1:0]      PER_CNT_MIN    = 9'h008;
  localparam logic [SDIV_CNT_W-1:0] SHARED_DIV_MIN = 9'h004;
  localparam logic [PDIV_CNT_W-1:0] PER_DIV_MIN    = 15'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [CNT_W-1:0] gdt_count_value(input logic per_mode, input logic [CNT_SEL_W-1:0] sel);
    if (per_mode) begin
      gdt_count_value = PER_CNT_MIN + {6'h00, sel};
    end else begin
      gdt_count_value = SHARED_CNT_MIN << sel;
    end
  endfunction : gdt_count_value

  function automatic logic [SDIV_CNT_W-1:0] gdt_shared_div_last(input logic [SDIV_SEL_W-1:0] sel);
    gdt_shared_div_last = (SHARED_DIV_MIN << sel) - 9'h001;
  endfunction : gdt_shared_div_last

  function automatic logic [PDIV_CNT_W-1:0] gdt_per_div_last(input logic [PDIV_SEL_W-1:0] sel);
    gdt_per_div_last = (PER_DIV_MIN << sel) - 15'h0001;
  endfunction : gdt_per_div_last

endpackage : gdt_pkg

// >>> logic/gdt_timer_if.sv
// Carrier between the bank controller and its timer slices
`timescale 1ns/1ps
interface gdt_timer_if #(parameter int N = 4);
  logic                                shared_tick;
  logic                                ref_tick;
  logic                                per_mode;
  logic [N-1:0]                        gate;
  logic [N-1:0][gdt_pkg::CNT_SEL_W-1:0]  cnt_sel;
  logic [N-1:0][gdt_pkg::PDIV_SEL_W-1:0] pdiv_sel;
  logic [N-1:0]                        tc;
  logic [N-1:0][gdt_pkg::CNT_W-1:0]      count;

  modport bank  (output shared_tick, ref_tick, per_mode, gate, cnt_sel, pdiv_sel, input tc, count);
  modport timer (input shared_tick, ref_tick, per_mode, gate, cnt_sel, pdiv_sel, output tc, count);
endinterface : gdt_timer_if

// >>> logic/gdt_timer.sv
// One gated down-counting delay timer with its own optional prescaler
`timescale 1ns/1ps
module gdt_timer #(
  parameter int IDX = 0,
  parameter int N   = 4
) (
  input wire logic    clk,
  input wire logic    rst_n,
  gdt_timer_if.timer  tif
);
  import gdt_pkg::*;

  logic [PDIV_CNT_W-1:0] pdiv_cnt;
  logic                  per_tick;
  logic                  tick;
  logic                  gate;
  logic [CNT_W-1:0]      load;

  initial begin
    if (IDX < 0 || IDX >= N) begin
      $error("gdt_timer: IDX out of range");
    end
  end

  assign gate = tif.gate[IDX];
  assign load = gdt_count_value(tif.per_mode, tif.cnt_sel[IDX]);
  assign per_tick = tif.ref_tick && (pdiv_cnt >= gdt_per_div_last(tif.pdiv_sel[IDX]));
  // Prescaler runs free so a gate edge lands anywhere in the period
  assign tick = tif.per_mode ? per_tick : tif.shared_tick;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdiv_cnt <= '0;
    end else if (tif.ref_tick) begin
      if (per_tick) begin
        pdiv_cnt <= '0;
      end else begin
        pdiv_cnt <= pdiv_cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tif.count[IDX] <= '0;
    end else if (!gate) begin
      tif.count[IDX] <= load;
    end else if (tick && tif.count[IDX] != '0) begin
      tif.count[IDX] <= tif.count[IDX] - 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tif.tc[IDX] <= 1'b0;
    end else if (!gate) begin
      tif.tc[IDX] <= 1'b0;
    end else if (tif.count[IDX] == '0 || (tick && tif.count[IDX] == 9'h001)) begin
      tif.tc[IDX] <= 1'b1;
    end
  end

endmodule : gdt_timer

// >>> logic/gdt_bank.sv
// Top of the gated delay timer bank: reference selection, shared prescaler, AXI4-Lite registers
`timescale 1ns/1ps
module gdt_bank #(
  parameter int NUM_TIMERS = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [gdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [gdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      ext_ref_clk,
  input  wire logic [NUM_TIMERS-1:0]     timer_gate,
  output logic [NUM_TIMERS-1:0]          timer_done
);
  import gdt_pkg::*;

  initial begin
    if (NUM_TIMERS < 1 || NUM_TIMERS > MAX_TIMERS) begin
      $error("gdt_bank: NUM_TIMERS must be 1 to 16");
    end
  end

  gdt_timer_if #(.N(NUM_TIMERS)) tif ();

  // Configuration registers
  logic [31:0] ctrl;
  logic [NUM_TIMERS-1:0][CNT_SEL_W-1:0]  cnt_sel;
  logic [NUM_TIMERS-1:0][PDIV_SEL_W-1:0] pdiv_sel;

  // Reference selection and prescaler state
  logic [7:0]            int_div_cnt;
  logic                  int_tick;
  logic                  ext_sync1;
  logic                  ext_sync2;
  logic                  ext_prev;
  logic                  ext_tick;
  logic                  ref_tick;
  logic [SDIV_CNT_W-1:0] sdiv_cnt;
  logic                  shared_tick;

  // Gate synchronisers
  logic [NUM_TIMERS-1:0] gate_sync1;
  logic [NUM_TIMERS-1:0] gate_sync2;

  // Bus state
  logic                  aw_held;
  logic                  w_held;
  logic [ADDR_W-1:0]     aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  do_write;

  localparam logic [7:0] INT_DIV_LAST = 8'(REF_DIV_CYCLES - 1);

  initial begin
    if (REF_DIV_CYCLES < 1 || REF_DIV_CYCLES > 256) begin
      $error("gdt_bank: reference divider does not fit its counter");
    end
  end

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction : merge_strb

  function automatic int timer_index(input logic [ADDR_W-1:0] addr);
    timer_index = (int'(addr) - int'(TIMER_CFG_OFFSET)) / 4;
  endfunction : timer_index

  function automatic logic is_timer_addr(input logic [ADDR_W-1:0] addr);
    is_timer_addr = (addr >= TIMER_CFG_OFFSET) && (addr[1:0] == 2'h0)
                    && (timer_index(addr) < NUM_TIMERS);
  endfunction : is_timer_addr

  // Internal 250 kHz reference as a one-cycle enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_div_cnt <= '0;
    end else if (int_div_cnt == INT_DIV_LAST) begin
      int_div_cnt <= '0;
    end else begin
      int_div_cnt <= int_div_cnt + 8'h01;
    end
  end
  assign int_tick = (int_div_cnt == INT_DIV_LAST);

  // External reference: two flops, then rising edge detect on the clean copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev  <= 1'b0;
    end else begin
      ext_sync1 <= ext_ref_clk;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end
  // External clock must stay below a quarter of clk for clean edge detection
  assign ext_tick = ext_sync2 && !ext_prev;

  assign ref_tick = ctrl[CTRL_REF_SEL_BIT] ? ext_tick : int_tick;

  // Shared prescaler, divide by 4 to 512
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdiv_cnt <= '0;
    end else if (ref_tick) begin
      if (shared_tick) begin
        sdiv_cnt <= '0;
      end else begin
        sdiv_cnt <= sdiv_cnt + 9'h001;
      end
    end
  end
  // Compare with >= so a smaller ratio written mid-count wraps at once
  assign shared_tick = ref_tick && (sdiv_cnt >= gdt_shared_div_last(ctrl[CTRL_SDIV_LSB +: SDIV_SEL_W]));

  // Gates arrive from outside logic, synchronise before use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_sync1 <= '0;
      gate_sync2 <= '0;
    end else begin
      gate_sync1 <= timer_gate;
      gate_sync2 <= gate_sync1;
    end
  end

  assign tif.shared_tick = shared_tick;
  assign tif.ref_tick    = ref_tick;
  assign tif.per_mode    = ctrl[CTRL_MODE_BIT];
  assign tif.gate        = gate_sync2;
  assign tif.cnt_sel     = cnt_sel;
  assign tif.pdiv_sel    = pdiv_sel;

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    gdt_timer #(
      .IDX (i),
      .N   (NUM_TIMERS)
    ) u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (tif.timer)
    );
  end

  assign timer_done = tif.tc;

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == CTRL_OFFSET || is_timer_addr(aw_addr)) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the select fields are writable; other bits except the timer count field read back as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (do_write && aw_addr == CTRL_OFFSET) begin
      ctrl <= merge_strb(ctrl, w_data, w_strb) & 32'h0000_001f;
    end
  end

  always_ff @(posedge clk) begin
    logic [31:0] cfg;
    cfg = '0;
    if (!rst_n) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        cnt_sel[t]  <= TIMER_CFG_RESET[TCFG_CNT_LSB +: CNT_SEL_W];
        pdiv_sel[t] <= TIMER_CFG_RESET[TCFG_PDIV_LSB +: PDIV_SEL_W];
      end
    end else if (do_write && is_timer_addr(aw_addr)) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (timer_index(aw_addr) == t) begin
          cfg = {24'h000000, pdiv_sel[t], 1'b0, cnt_sel[t]};
          cfg = merge_strb(cfg, w_data, w_strb);
          cnt_sel[t]  <= cfg[TCFG_CNT_LSB +: CNT_SEL_W];
          pdiv_sel[t] <= cfg[TCFG_PDIV_LSB +: PDIV_SEL_W];
        end
      end
    end
  end

  // AXI4-Lite read, one outstanding
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr == CTRL_OFFSET) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == STATUS_OFFSET) begin
        s_axi_rdata[NUM_TIMERS-1:0] <= tif.tc;
        s_axi_rdata[STATUS_GATE_LSB +: NUM_TIMERS] <= gate_sync2;
      end else if (is_timer_addr(s_axi_araddr)) begin
        for (int t = 0; t < NUM_TIMERS; t++) begin
          if (timer_index(s_axi_araddr) == t) begin
            s_axi_rdata[TCFG_CNT_LSB +: CNT_SEL_W]   <= cnt_sel[t];
            s_axi_rdata[TCFG_PDIV_LSB +: PDIV_SEL_W] <= pdiv_sel[t];
            s_axi_rdata[TCFG_COUNT_LSB +: CNT_W]     <= tif.count[t];
          end
        end
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : gdt_bank

// >>> verification/gdt_bank_checker.sv
// Port-level assertions for the gated delay timer bank
`timescale 1ns/1ps
module gdt_bank_checker #(
  parameter int NUM_TIMERS = 4
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [NUM_TIMERS-1:0] timer_gate,
  input wire logic [NUM_TIMERS-1:0] timer_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_retires: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (timer_done[0] && !timer_gate[0]);

  // Gate goes through two sync flops, so flag reactions lag the pin
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    a_gate_clears: assert property (!timer_gate[i] [*4] |-> !timer_done[i])
      else $error("flag high with gate low");
    a_flag_holds: assert property (timer_gate[i] [*3] ##0 timer_done[i] |=> timer_done[i])
      else $error("flag fell while gate high");
    a_rise_gated: assert property ($rose(timer_done[i]) |-> $past(timer_gate[i], 2) && $past(timer_gate[i], 8))
      else $error("flag rose without gate");
    cover property ($rose(timer_done[i]));
  end
endmodule : gdt_bank_checker

bind gdt_bank gdt_bank_checker #(.NUM_TIMERS(NUM_TIMERS)) u_chk (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_gate(timer_gate), .timer_done(timer_done)
);

// >>> verification/gdt_seq_model.sv
// Sequencing logic model: drives timer gates, watches terminal-count flags
`timescale 1ns/1ps
module gdt_seq_model #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] monitored_supply_input,
  input  wire logic [N-1:0] timer_done,
  output logic      [N-1:0] timer_gate,
  output logic      [N-1:0] step_advanced
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_gate <= '0;
    end else begin
      timer_gate <= monitored_supply_input;
    end
  end

  // Step moves on only while the gate is held and the flag reads high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_advanced <= '0;
    end else begin
      step_advanced <= timer_gate & timer_done;
    end
  end
endmodule : gdt_seq_model

// >>> verification/gdt_bank_tb.sv
// Self-checking bench for the gated delay timer bank
`timescale 1ns/1ps
module gdt_bank_tb;
  import gdt_pkg::*;
  localparam int NT = 4;
  logic              clk, rst_n, ext_ref_clk;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata, rd;
  logic [1:0]        bresp, rresp, rs;
  logic [3:0]        wstrb;
  logic [2:0]        ref_cnt;
  logic [NT-1:0]     mon, gate, done, adv;
  int                n_mismatch, total_checks;

  gdt_bank #(.NUM_TIMERS(NT)) u_dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_ref_clk(ext_ref_clk), .timer_gate(gate),
    .timer_done(done)
  );
  gdt_seq_model #(.N(NT)) u_seq (
    .clk(clk), .rst_n(rst_n), .monitored_supply_input(mon), .timer_done(done),
    .timer_gate(gate), .step_advanced(adv)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // External reference: one rising edge every 8 clocks, well under clk/4
  always @(posedge clk) begin
    if (!rst_n) begin
      ref_cnt     <= 3'h0;
      ext_ref_clk <= 1'b0;
    end else begin
      ref_cnt     <= ref_cnt + 3'h1;
      ext_ref_clk <= ref_cnt[2];
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic hung(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : hung

  // Readiness is sampled on the falling edge, where it equals its value at the next rising edge
  // Response ready is raised only once the answer shows, so the slave must hold it a cycle
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok, b_seen;
    int   k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_seen = (bvalid === 1'b1);
      b_ok = b_seen && bready;
      r = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      bready <= b_seen && !b_ok;
      k++;
    end while (!b_ok && k < 50);
    hung(k, 50);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok, r_seen;
    int   k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_seen = (rvalid === 1'b1);
      r_ok = r_seen && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
      rready <= r_seen && !r_ok;
      k++;
    end while (!r_ok && k < 50);
    hung(k, 50);
  endtask : axi_read

  // Raise the monitored input, time the flag, then hold and release the gate
  task automatic run_timer(input int i, input int m, input int p);
    int n;
    @(posedge clk);
    mon[i] <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done[i] !== 1'b1 && n < m * p + 40);
    hung(n, m * p + 40);
    check("delay window", 32'(n >= (m - 1) * p && n <= m * p + 8), 32'h1);
    repeat (20) @(negedge clk);
    check("flag held", {31'h0, done[i]}, 32'h1);
    check("step advanced", {31'h0, adv[i]}, 32'h1);
    axi_read(STATUS_OFFSET, rd, rs);
    check("status flag", {31'h0, rd[i]}, 32'h1);
    axi_read(TIMER_CFG_OFFSET + 8'(4 * i), rd, rs);
    check("counter at zero", 32'(rd[24:16]), 32'h0);
    @(posedge clk);
    mon[i] <= 1'b0;
    repeat (6) @(negedge clk);
    check("flag cleared", {31'h0, done[i]}, 32'h0);
    axi_read(TIMER_CFG_OFFSET + 8'(4 * i), rd, rs);
    check("counter reloaded", 32'(rd[24:16]), 32'(m));
  endtask : run_timer

  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst_n = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'hf;
    mon = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    axi_read(CTRL_OFFSET, rd, rs);
    check("ctrl reset", rd, CTRL_RESET);
    axi_read(TIMER_CFG_OFFSET, rd, rs);
    check("cfg reset", rd, 32'h0002_0000);
    axi_read(8'h08, rd, rs);
    check("unmapped data", rd, 32'h0);
    check("unmapped rresp", 32'(rs), 32'(RESP_SLVERR));
    axi_write(8'h0c, 32'hffff_ffff, rs);
    check("unmapped bresp", 32'(rs), 32'(RESP_SLVERR));
    run_timer(0, 2, 4 * REF_DIV_CYCLES);
    axi_write(CTRL_OFFSET, 32'h1, rs);
    check("ctrl bresp", 32'(rs), 32'(RESP_OKAY));
    for (int s = 0; s < 8; s++) begin
      axi_write(TIMER_CFG_OFFSET + 8'h04, 32'(s), rs);
      run_timer(1, 2 << s, 32);
    end
    for (int d = 0; d < 8; d++) begin
      axi_write(CTRL_OFFSET, 32'(1 + 4 * d), rs);
      run_timer(0, 2, 8 * (4 << d));
    end
    axi_write(CTRL_OFFSET, 32'h1, rs);
    axi_write(TIMER_CFG_OFFSET + 8'h0c, 32'h7, rs);
    @(posedge clk);
    mon[3] <= 1'b1;
    repeat (200) @(posedge clk);
    axi_read(TIMER_CFG_OFFSET + 8'h0c, rd, rs);
    check("counter falling", 32'(rd[24:16] >= 9'd248 && rd[24:16] <= 9'd252), 32'h1);
    check("flag low midway", {31'h0, done[3]}, 32'h0);
    @(posedge clk);
    mon[3] <= 1'b0;
    axi_write(CTRL_OFFSET, 32'h3, rs);
    for (int s = 0; s < 8; s++) begin
      axi_write(TIMER_CFG_OFFSET + 8'h08, 32'(s + 32), rs);
      run_timer(2, 8 + s, 32);
    end
    axi_write(TIMER_CFG_OFFSET + 8'h0c, 32'h57, rs);
    run_timer(3, 15, 256);
    axi_write(TIMER_CFG_OFFSET + 8'h0c, 32'h0, rs);
    run_timer(3, 8, 8);
    give_verdict();
  end
endmodule : gdt_bank_tb
